// ### src/tpw_timer.v
// Purpose: Three-channel 16-bit PWM timer with compare flags and per-flag interrupt enables
// Assumes: Register port is synchronous, read data one cycle after the read strobe
// Notes: Outputs are plain levels; pins are driven only while counting
// Operation
// - With clear select 001 the counter returns to zero on a match with the period register.
// - A three-bit field picks clock, clock/2, /4, /8, /32 or the external count clock.
// - Interrupt A is raised only while enable A and flag A are both set.
// - Enables B, C and D at bits 1 to 3 gate the interrupts of flags B, C and D.
// - Polarity bits 0 to 2 make outputs B, C and D active high when 1, active low when 0.
// - The period register is a full 16-bit value counted in source ticks.
// - Output B changes when the counter matches change point B.
// - Output C changes when the counter matches change point C.
// - Flag A is set on a source tick while the counter equals the period register.
// - Initial level bits choose inactive (0) or active (1) output when counting starts.
`timescale 1ns/10ps
`default_nettype none
`include "tpw_map.vh"
module tpw_timer
#(
  parameter CNT_W = 16
)
(
  input wire sys_clk_i,
  input wire nrst_i,
  input wire [`TPW_ADDR_W-1:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  input wire external_count_clock_i,
  output reg pwm_out_b_o,
  output reg pwm_out_c_o,
  output reg pwm_out_d_o,
  output reg [2:0] pwm_oe_o,
  output wire compare_irq_a_o,
  output wire compare_irq_b_o,
  output wire compare_irq_c_o,
  output wire compare_irq_d_o
);
  reg rst_s1_q;
  reg rst_n_q;
  reg [7:0] timer_control_zero_q;
  reg [7:0] compare_interrupt_enable_q;
  reg [7:0] pwm_output_polarity_q;
  reg [CNT_W-1:0] period_register_q;
  reg [CNT_W-1:0] change_point_b_q;
  reg [CNT_W-1:0] change_point_c_q;
  reg [CNT_W-1:0] change_point_d_q;
  reg [CNT_W-1:0] timer_counter_q;
  reg [3:0] flags_q;
  reg [3:0] flag_seen_q;
  reg [2:0] init_level_q;
  reg [2:0] act_q;
  reg start_q;
  reg start_prev_q;
  wire tick;
  wire match_a;
  wire [2:0] match_pt;
  wire [3:0] flag_set;
  wire [3:0] flag_clr;
  wire status_wr;
  reg [15:0] rdata_d;

  // Reset released through two flops so every register leaves reset together
  always @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  tpw_prescale u_prescale
  (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n_q),
    .run_i(start_q),
    .sel_i(timer_control_zero_q[2:0]),
    .ext_clk_i(external_count_clock_i),
    .tick_o(tick)
  );

  // Compares are qualified by the tick so each match acts once per source count
  assign match_a = tick && (timer_counter_q == period_register_q);
  assign match_pt[0] = tick && (timer_counter_q == change_point_b_q);
  assign match_pt[1] = tick && (timer_counter_q == change_point_c_q);
  assign match_pt[2] = tick && (timer_counter_q == change_point_d_q);
  assign flag_set = {match_pt, match_a};
  assign status_wr = wr_i && (addr_i == `TPW_OFS_STATUS);
  // Only flags read as 1 since the last status read may be cleared by a 0 write
  assign flag_clr = status_wr ? (flag_seen_q & ~wdata_i[3:0]) : 4'h0;

  // Interrupt lines: flag AND enable
  assign compare_irq_a_o = flags_q[0] & compare_interrupt_enable_q[0];
  assign compare_irq_b_o = flags_q[1] & compare_interrupt_enable_q[1];
  assign compare_irq_c_o = flags_q[2] & compare_interrupt_enable_q[2];
  assign compare_irq_d_o = flags_q[3] & compare_interrupt_enable_q[3];

  // Register writes
  always @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      timer_control_zero_q <= `TPW_CTRL_RST;
      compare_interrupt_enable_q <= `TPW_IEN_RST;
      pwm_output_polarity_q <= `TPW_POL_RST;
      period_register_q <= `TPW_GR_RST;
      change_point_b_q <= `TPW_GR_RST;
      change_point_c_q <= `TPW_GR_RST;
      change_point_d_q <= `TPW_GR_RST;
      init_level_q <= 3'h0;
      start_q <= 1'b0;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `TPW_OFS_CTRL: timer_control_zero_q <= wdata_i[7:0];
        `TPW_OFS_IEN: compare_interrupt_enable_q <= {3'h0, wdata_i[4:0]};
        `TPW_OFS_POL: pwm_output_polarity_q <= {5'h00, wdata_i[2:0]};
        `TPW_OFS_PERIOD: period_register_q <= wdata_i[CNT_W-1:0];
        `TPW_OFS_CPB: change_point_b_q <= wdata_i[CNT_W-1:0];
        `TPW_OFS_CPC: change_point_c_q <= wdata_i[CNT_W-1:0];
        `TPW_OFS_CPD: change_point_d_q <= wdata_i[CNT_W-1:0];
        `TPW_OFS_START: start_q <= wdata_i[0];
        `TPW_OFS_INITLV: init_level_q <= wdata_i[2:0];
        default: start_q <= start_q;
      endcase
    end
  end

  // Flags: a hardware set in the same cycle as a clear wins
  always @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      flags_q <= 4'h0;
      flag_seen_q <= 4'h0;
    end
    else
    begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
      if (rd_i && (addr_i == `TPW_OFS_STATUS))
        flag_seen_q <= flags_q;
      else
        flag_seen_q <= flag_seen_q & ~flag_clr;
    end
  end

  // Counter: clears on period match when clear select is 001, else wraps freely
  always @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      timer_counter_q <= {CNT_W{1'b0}};
    else if (!start_q)
      timer_counter_q <= timer_counter_q;
    else if (match_a && timer_control_zero_q[7:5] == `TPW_CLR_PERIOD)
      timer_counter_q <= {CNT_W{1'b0}};
    else if (tick)
      timer_counter_q <= timer_counter_q + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  // Active state per output: load initial level at start, set at change point,
  // back to initial level at period match; a change point equal to the period
  // loses, so such a channel stays at its initial level
  always @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      act_q <= 3'h0;
      start_prev_q <= 1'b0;
    end
    else
    begin
      start_prev_q <= start_q;
      if (start_q && !start_prev_q)
        act_q <= init_level_q;
      else if (match_a)
        act_q <= init_level_q;
      else
        act_q <= act_q | match_pt;
    end
  end

  // Pin levels from flops: polarity maps active to high or low
  always @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pwm_out_b_o <= 1'b0;
      pwm_out_c_o <= 1'b0;
      pwm_out_d_o <= 1'b0;
      pwm_oe_o <= 3'h0;
    end
    else
    begin
      pwm_out_b_o <= ~(act_q[0] ^ pwm_output_polarity_q[0]);
      pwm_out_c_o <= ~(act_q[1] ^ pwm_output_polarity_q[1]);
      pwm_out_d_o <= ~(act_q[2] ^ pwm_output_polarity_q[2]);
      pwm_oe_o <= {3{start_q}};
    end
  end

  // Read mux; unmapped addresses read zero
  always @*
  begin
    case (addr_i)
      `TPW_OFS_CTRL: rdata_d = {8'h00, timer_control_zero_q};
      `TPW_OFS_IEN: rdata_d = {8'h00, compare_interrupt_enable_q};
      `TPW_OFS_POL: rdata_d = {8'h00, pwm_output_polarity_q};
      `TPW_OFS_PERIOD: rdata_d = period_register_q;
      `TPW_OFS_CPB: rdata_d = change_point_b_q;
      `TPW_OFS_CPC: rdata_d = change_point_c_q;
      `TPW_OFS_CPD: rdata_d = change_point_d_q;
      `TPW_OFS_STATUS: rdata_d = {12'h000, flags_q};
      `TPW_OFS_START: rdata_d = {15'h0000, start_q};
      `TPW_OFS_INITLV: rdata_d = {13'h0000, init_level_q};
      `TPW_OFS_COUNT: rdata_d = timer_counter_q;
      default: rdata_d = 16'h0000;
    endcase
  end

  // Read data registered, valid only in the cycle after the strobe
  always @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      rdata_o <= 16'h0000;
    else if (rd_i)
      rdata_o <= rdata_d;
    else
      rdata_o <= 16'h0000;
  end
endmodule // tpw_timer
`default_nettype wire

// ### pkg/tpw_map.vh
// Purpose: Register offsets, field positions and reset values of the three-channel PWM timer
// Assumes: Word-indexed register port, 16-bit data
// Notes: Definitions only
`ifndef TPW_MAP_VH
`define TPW_MAP_VH
`define TPW_ADDR_W 4
`define TPW_OFS_CTRL 4'h0
`define TPW_OFS_IEN 4'h1
`define TPW_OFS_POL 4'h2
`define TPW_OFS_PERIOD 4'h3
`define TPW_OFS_CPB 4'h4
`define TPW_OFS_CPC 4'h5
`define TPW_OFS_CPD 4'h6
`define TPW_OFS_STATUS 4'h7
`define TPW_OFS_START 4'h8
`define TPW_OFS_INITLV 4'h9
`define TPW_OFS_COUNT 4'hA
`define TPW_CLR_PERIOD 3'h1
`define TPW_CLR_LSB 5
`define TPW_SRC_CLK 3'h0
`define TPW_SRC_DIV2 3'h1
`define TPW_SRC_DIV4 3'h2
`define TPW_SRC_DIV8 3'h3
`define TPW_SRC_DIV32 3'h4
`define TPW_SRC_EXT 3'h5
`define TPW_CTRL_RST 8'h00
`define TPW_IEN_RST 8'h00
`define TPW_POL_RST 8'h00
`define TPW_GR_RST 16'hFFFF
`endif

// ### src/tpw_prescale.v
// Purpose: Count-source enable generator for the PWM timer
// Assumes: External count clock is synchronous to sys_clk_i
// Notes: Emits a one-cycle tick per source count
`timescale 1ns/10ps
`default_nettype none
`include "tpw_map.vh"
module tpw_prescale
(
  input wire clk_i,
  input wire rst_n_i,
  input wire run_i,
  input wire [2:0] sel_i,
  input wire ext_clk_i,
  output reg tick_o
);
  reg [4:0] div_q;
  reg ext_q;

  // Free divider plus edge detect of the external clock
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_q <= 5'h00;
      ext_q <= 1'b0;
    end
    else
    begin
      div_q <= run_i ? div_q + 5'h01 : 5'h00;
      ext_q <= ext_clk_i;
    end
  end

  // Source select; unused codes never tick, so a forbidden code just stalls
  always @*
  begin
    case (sel_i)
      `TPW_SRC_CLK: tick_o = run_i;
      `TPW_SRC_DIV2: tick_o = run_i && (div_q[0] == 1'b1);
      `TPW_SRC_DIV4: tick_o = run_i && (div_q[1:0] == 2'h3);
      `TPW_SRC_DIV8: tick_o = run_i && (div_q[2:0] == 3'h7);
      `TPW_SRC_DIV32: tick_o = run_i && (div_q == 5'h1F);
      `TPW_SRC_EXT: tick_o = run_i && ext_clk_i && !ext_q;
      default: tick_o = 1'b0;
    endcase
  end
endmodule // tpw_prescale
`default_nettype wire

// ### tb/tpw_load.sv
// Purpose: Loads on the three PWM pins
// Assumes: Weak pull-downs on every pin
// Notes: A released pin reads 0, not its last value
`timescale 1ns/10ps
`default_nettype none
module tpw_load
(
  input wire logic [2:0] pin_i,
  input wire logic [2:0] oe_i,
  output logic [2:0] lvl_o
);
  // Pull-down wins where the timer does not drive
  assign lvl_o = pin_i & oe_i;
endmodule // tpw_load
`default_nettype wire

// ### tb/tpw_timer_chk.sv
// Purpose: Port checker of the PWM timer
// Assumes: Word map of tpw_map.vh
// Notes: Bound into every tpw_timer
`timescale 1ns/10ps
`default_nettype none
`include "tpw_map.vh"
module tpw_timer_chk
#(
  parameter CNT_W = 16
)
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [`TPW_ADDR_W-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic [2:0] pwm_oe_o,
  input wire logic compare_irq_a_o,
  input wire logic compare_irq_b_o,
  input wire logic compare_irq_c_o,
  input wire logic compare_irq_d_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // A cleared enable silences its interrupt at once
  property p_mask_a; wr_i && addr_i == `TPW_OFS_IEN && !wdata_i[0] |=> !compare_irq_a_o; endproperty
  a_mask_a: assert property (p_mask_a) else $error("irq a not masked");
  property p_mask_b; wr_i && addr_i == `TPW_OFS_IEN && !wdata_i[1] |=> !compare_irq_b_o; endproperty
  a_mask_b: assert property (p_mask_b) else $error("irq b not masked");
  property p_mask_c; wr_i && addr_i == `TPW_OFS_IEN && !wdata_i[2] |=> !compare_irq_c_o; endproperty
  a_mask_c: assert property (p_mask_c) else $error("irq c not masked");
  property p_mask_d; wr_i && addr_i == `TPW_OFS_IEN && !wdata_i[3] |=> !compare_irq_d_o; endproperty
  a_mask_d: assert property (p_mask_d) else $error("irq d not masked");
  // Read data stand only after a read, so a stale word cannot leak
  property p_idle; !rd_i |=> rdata_o == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_unmap; rd_i && addr_i > `TPW_OFS_COUNT |=> rdata_o == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // Interrupt A drops only by a write; it rises only from a count or an enable write.
  // A restart with the counter parked on the period matches at the first tick,
  // before the enable flop has caught up, so the current enable is the witness.
  property p_fall_a; $fell(compare_irq_a_o) |-> $past(wr_i); endproperty
  a_fall_a: assert property (p_fall_a) else $error("irq a fell unasked");
  property p_rise_a; $rose(compare_irq_a_o) |-> pwm_oe_o[0] || $past(wr_i); endproperty
  a_rise_a: assert property (p_rise_a) else $error("irq a rose idle");
  property p_stop; wr_i && addr_i == `TPW_OFS_START && !wdata_i[0] |-> ##[1:3] pwm_oe_o == 3'h0;
  endproperty
  a_stop: assert property (p_stop) else $error("pins still driven");
endmodule // tpw_timer_chk
bind tpw_timer tpw_timer_chk #(.CNT_W(CNT_W)) chk_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .pwm_oe_o(pwm_oe_o), .compare_irq_a_o(compare_irq_a_o), .compare_irq_b_o(compare_irq_b_o),
  .compare_irq_c_o(compare_irq_c_o), .compare_irq_d_o(compare_irq_d_o));
`default_nettype wire

// ### tb/tpw_timer_chk_tb_top.sv
// Purpose: Self-checking bench of the PWM timer
// Assumes: 50 MHz clock, one-cycle bus strobes
// Notes: Pins are measured through the load model
`timescale 1ns/10ps
`default_nettype none
`include "tpw_map.vh"
module tpw_timer_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ext = 1'b0;
  logic prev = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic pb, pc, pd, ia, ib, ic, id;
  logic [2:0] oe, lv;
  int cyc = 0;
  int last = 0;
  int per = 0;
  int bad_count = 0;
  int n_compared = 0;
  int i, nb, nc, nd;
  int dv[6] = '{1, 2, 4, 8, 32, 4};
  tpw_timer dut_u (.sys_clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .external_count_clock_i(ext), .pwm_out_b_o(pb),
    .pwm_out_c_o(pc), .pwm_out_d_o(pd), .pwm_oe_o(oe), .compare_irq_a_o(ia),
    .compare_irq_b_o(ib), .compare_irq_c_o(ic), .compare_irq_d_o(id));
  tpw_load load_u (.pin_i({pd, pc, pb}), .oe_i(oe), .lvl_o(lv));
  initial forever #10 clk = ~clk;
  // External clock rises every fourth cycle; pin B period; hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    ext <= cyc[1];
    prev <= lv[0];
    if (lv[0] === 1'b1 && prev === 1'b0)
    begin
      per <= cyc - last;
      last <= cyc;
    end
    if (cyc == 10000)
    begin
      bad_count++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, exp, rdata);
  endtask
  task summarize;
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Period 10 counts, change points 3/5/7, B and C active high, D active low
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rchk("period", `TPW_OFS_PERIOD, 16'hFFFF);
    rchk("unmapped", 4'hF, 16'h0000);
    wreg(`TPW_OFS_PERIOD, 16'h0009);
    wreg(`TPW_OFS_CPB, 16'h0003);
    wreg(`TPW_OFS_CPC, 16'h0005);
    wreg(`TPW_OFS_CPD, 16'h0007);
    wreg(`TPW_OFS_POL, 16'h0003);
    wreg(`TPW_OFS_INITLV, 16'h0007);
    wreg(`TPW_OFS_IEN, 16'h000F);
    wreg(`TPW_OFS_CTRL, 16'h0020);
    wreg(`TPW_OFS_START, 16'h0001);
    repeat (2) @(posedge clk);
    #1 chk("init", 16'h0003, {13'h0, lv});
    wreg(`TPW_OFS_START, 16'h0000);
    wreg(`TPW_OFS_INITLV, 16'h0000);
    wreg(`TPW_OFS_START, 16'h0001);
    repeat (30) @(posedge clk);
    nb = 0;
    nc = 0;
    nd = 0;
    // Active cycles per period equal period register minus change point
    repeat (10)
    begin
      @(posedge clk);
      #1 nb += lv[0];
      nc += lv[1];
      nd += !lv[2];
    end
    chk("duty_b", 16'd6, nb[15:0]);
    chk("duty_c", 16'd4, nc[15:0]);
    chk("duty_d", 16'd2, nd[15:0]);
    for (i = 0; i < 6; i++)
    begin
      wreg(`TPW_OFS_CTRL, {8'h00, `TPW_CLR_PERIOD, 2'h0, i[2:0]});
      repeat (40 * dv[i] + 20) @(posedge clk);
      chk("period", 16'(10 * dv[i]), per[15:0]);
    end
    // Blind zero keeps the flags; read then zero clears them
    wreg(`TPW_OFS_START, 16'h0000);
    chk("irqs", 16'h000F, {12'h0, ia, ib, ic, id});
    wreg(`TPW_OFS_STATUS, 16'h0000);
    rchk("status", `TPW_OFS_STATUS, 16'h000F);
    wreg(`TPW_OFS_STATUS, 16'h0000);
    rchk("status", `TPW_OFS_STATUS, 16'h0000);
    // Back to the system clock so the next run passes both matches A and C
    wreg(`TPW_OFS_CTRL, 16'h0020);
    wreg(`TPW_OFS_START, 16'h0001);
    repeat (30) @(posedge clk);
    wreg(`TPW_OFS_START, 16'h0000);
    wreg(`TPW_OFS_IEN, 16'h0000);
    chk("irq_off", 16'h0000, {12'h0, ia, ib, ic, id});
    wreg(`TPW_OFS_IEN, 16'h0005);
    chk("irq_ac", 16'h000A, {12'h0, ia, ib, ic, id});
    summarize();
  end
endmodule // tpw_timer_tb_top
`default_nettype wire
